/* File: rtl/gport_device.sv */
// Arbiter/target end: issues grants with status, moves data with strobes.
// Assumes link_clk from the bench; user side runs on i_mclk.
// Function
// - Device always drives grant_status outward
// - Master reads status only under grant
// - Code 000 returns low-priority read data
// - Code 001 high read; reserved new mode
// - Code 010 asks low-priority write data
// - Code 011 high write; reserved new mode
// - Code 111 permits master start transaction
// - Lower strobe times bits 15:0, be 1:0; this device latches them on the upper first strobe
// - Upper strobe times bits 31:16, be 3:2
// - Old mode strobe has complement partner
// - First strobe rises on odd items
// - Second strobe rises on even items
// - Upper first strobe also times inversion flags
// - Master drives sideband strobe when enabled; this master ties it low
// - Grant serves both start and data
// - No low read while buffer full
// - Invert upper half when flag set
`timescale 1ns/100ps
`default_nettype none
module gport_device
   import gport_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_req_valid,
   input wire req_kind_t i_req_kind,
   input wire logic [31:0] i_req_data,
   input wire logic [3:0] i_req_be,
   output logic o_req_ready,
   input wire logic i_start_grant,
   output logic o_rx_valid,
   output logic [31:0] o_rx_data,
   output logic [3:0] o_rx_be,
   input wire logic i_rx_ready,
   output logic [7:0] o_sb_addr,
   output logic o_sb_valid,
   gport_if.device link
);
   // ==========================================
   // Request buffer, user to link (gray pointers, two entries)
   logic [31:0] q_data [BUF_DEPTH];
   logic [3:0] q_be [BUF_DEPTH];
   req_kind_t q_kind [BUF_DEPTH];
   logic [1:0] wr_ptr;
   logic [1:0] rd_ptr;
   logic [1:0] rd_ptr_s1;
   logic [1:0] rd_ptr_s2;
   logic [1:0] wr_ptr_s1;
   logic [1:0] wr_ptr_s2;
   logic start_tgl;
   logic start_s1;
   logic start_s2;
   logic start_s3;
   wire logic [1:0] wr_gray = {wr_ptr[1], wr_ptr[1] ^ wr_ptr[0]};
   wire logic [1:0] rd_gray = {rd_ptr[1], rd_ptr[1] ^ rd_ptr[0]};
   wire logic full_m = (wr_gray == {~rd_ptr_s2[1], ~rd_ptr_s2[0]});
   wire logic empty_l = (rd_gray == wr_ptr_s2);
   wire logic push = i_req_valid && !full_m;
   // Write side on user clock
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         wr_ptr <= 2'h0;
         rd_ptr_s1 <= 2'h0;
         rd_ptr_s2 <= 2'h0;
         o_req_ready <= 1'b0;
         start_tgl <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 2'h1;
         rd_ptr_s1 <= rd_gray;
         rd_ptr_s2 <= rd_ptr_s1;
         o_req_ready <= !full_m && !push;
         if (i_start_grant)
            start_tgl <= ~start_tgl;
      end
   end
   // Storage write
   always_ff @(posedge i_mclk)
   begin
      if (push)
      begin
         q_data[wr_ptr[0]] <= i_req_data;
         q_be[wr_ptr[0]] <= i_req_be;
         q_kind[wr_ptr[0]] <= i_req_kind;
      end
   end
   // ==========================================
   // Link side state machine
   typedef enum logic [1:0] {S_IDLE, S_GRANT, S_DATA, S_START} state_t;
   state_t state;
   logic [1:0] beat;
   req_kind_t cur_kind;
   logic [31:0] cur_data;
   logic [3:0] cur_be;
   wire req_kind_t head_kind = q_kind[rd_ptr[0]];
   // Reserved high codes refused in new mode; low read held off by full buffer
   wire logic head_bad = link.new_mode &&
      (head_kind == REQ_READ_HI || head_kind == REQ_WRITE_HI);
   wire logic head_ok = !empty_l && !head_bad &&
      !(head_kind == REQ_READ_LO && link.read_buffer_full);
   wire logic start_ev = start_s2 ^ start_s3;
   // Code selection; only the four data codes and start are reachable
   function automatic logic [2:0] kind_code(input req_kind_t k);
      case (k)
         REQ_READ_LO: kind_code = ST_READ_LO;
         REQ_READ_HI: kind_code = ST_READ_HI;
         REQ_WRITE_LO: kind_code = ST_WRITE_LO;
         REQ_WRITE_HI: kind_code = ST_WRITE_HI;
         default: kind_code = ST_START;
      endcase
   endfunction
   wire logic is_read = (cur_kind == REQ_READ_LO || cur_kind == REQ_READ_HI);
   always_ff @(posedge link.link_clk)
   begin
      if (i_rst)
      begin
         state <= S_IDLE;
         rd_ptr <= 2'h0;
         wr_ptr_s1 <= 2'h0;
         wr_ptr_s2 <= 2'h0;
         start_s1 <= 1'b0;
         start_s2 <= 1'b0;
         start_s3 <= 1'b0;
         link.bus_grant <= 1'b0;
         link.grant_status <= ST_START;
         link.dev_oe <= 1'b0;
         link.dev_stb_first <= 2'h0;
         link.dev_stb_second <= 2'h0;
         beat <= 2'h0;
         cur_kind <= REQ_READ_LO;
         cur_data <= 32'h0;
         cur_be <= 4'h0;
      end
      else
      begin
         wr_ptr_s1 <= wr_gray;
         wr_ptr_s2 <= wr_ptr_s1;
         start_s1 <= start_tgl;
         start_s2 <= start_s1;
         start_s3 <= start_s2;
         case (state)
            S_IDLE:
            begin
               link.bus_grant <= 1'b0;
               link.dev_oe <= 1'b0;
               if (!empty_l && head_bad)
                  rd_ptr <= rd_ptr + 2'h1; // reserved kind dropped
               else if (head_ok)
               begin
                  cur_kind <= head_kind;
                  cur_data <= q_data[rd_ptr[0]];
                  cur_be <= q_be[rd_ptr[0]];
                  rd_ptr <= rd_ptr + 2'h1;
                  link.bus_grant <= 1'b1;
                  link.grant_status <= kind_code(head_kind);
                  state <= S_GRANT;
               end
               else if (start_ev)
               begin
                  link.bus_grant <= 1'b1;
                  link.grant_status <= ST_START;
                  state <= S_START;
               end
            end
            S_GRANT:
            begin
               link.bus_grant <= 1'b0;
               beat <= 2'h0;
               link.dev_oe <= is_read;
               state <= S_DATA;
            end
            S_DATA:
            begin
               beat <= beat + 2'h1;
               // Alternate first/second strobe rises per item
               if (is_read)
               begin
                  link.dev_stb_first <= {2{~beat[0]}};
                  link.dev_stb_second <= {2{beat[0]}};
               end
               if (beat == 2'h3)
               begin
                  link.dev_oe <= 1'b0;
                  link.dev_stb_first <= 2'h0;
                  link.dev_stb_second <= 2'h0;
                  state <= S_IDLE;
               end
            end
            S_START:
            begin
               link.bus_grant <= 1'b0;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
   // Read data lanes: inversion disabled when transmitting
   assign link.dev_ad = cur_data;
   assign link.dev_cbe = cur_be;
   assign link.dev_inv_hi = 1'b0;
   assign link.dev_inv_lo = 1'b0;
   // ==========================================
   // Receive path: captured on first strobe, crossed by toggle
   logic [31:0] rx_word;
   logic [3:0] rx_be;
   logic rx_tgl;
   logic stb_d;
   wire logic [31:0] rx_fix = {link.bus_invert_hi ? ~link.addr_data_bus[31:16] :
      link.addr_data_bus[31:16],
      link.bus_invert_lo ? ~link.addr_data_bus[15:0] : link.addr_data_bus[15:0]};
   always_ff @(posedge link.link_clk)
   begin
      if (i_rst)
      begin
         rx_tgl <= 1'b0;
         stb_d <= 1'b0;
         rx_word <= 32'h0;
         rx_be <= 4'h0;
      end
      else
      begin
         stb_d <= link.strobe_first[1];
         if (link.mst_oe && link.strobe_first[1] && !stb_d)
         begin
            rx_word <= rx_fix;
            rx_be <= link.cmd_byte_enable;
            rx_tgl <= ~rx_tgl;
         end
      end
   end
   logic rx_s1;
   logic rx_s2;
   logic rx_s3;
   logic spare_v;
   logic [31:0] spare_data;
   logic [3:0] spare_be;
   // Second buffer entry keeps a word while the user stalls
   wire logic rx_ev = rx_s2 ^ rx_s3;
   wire logic out_free = !o_rx_valid || i_rx_ready;
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         rx_s1 <= 1'b0;
         rx_s2 <= 1'b0;
         rx_s3 <= 1'b0;
         spare_v <= 1'b0;
         spare_data <= 32'h0;
         spare_be <= 4'h0;
         o_rx_valid <= 1'b0;
         o_rx_data <= 32'h0;
         o_rx_be <= 4'h0;
      end
      else
      begin
         rx_s1 <= rx_tgl;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (out_free && spare_v)
         begin
            o_rx_valid <= 1'b1;
            o_rx_data <= spare_data;
            o_rx_be <= spare_be;
            spare_v <= rx_ev;
         end
         else if (out_free)
         begin
            o_rx_valid <= rx_ev;
            if (rx_ev)
            begin
               o_rx_data <= rx_word;
               o_rx_be <= rx_be;
            end
         end
         else if (rx_ev)
            spare_v <= 1'b1;
         if (rx_ev && !(out_free && !spare_v))
         begin
            spare_data <= rx_word;
            spare_be <= rx_be;
         end
      end
   end
   // ==========================================
   // Sideband capture on sideband first strobe, user-side output
   logic sb_d;
   logic [7:0] sb_word;
   logic sb_tgl;
   logic sb_s1;
   logic sb_s2;
   logic sb_s3;
   always_ff @(posedge link.link_clk)
   begin
      if (i_rst)
      begin
         sb_d <= 1'b0;
         sb_word <= 8'h0;
         sb_tgl <= 1'b0;
      end
      else
      begin
         sb_d <= link.sideband_strobe_first;
         if (link.sideband_4x_enable && link.sideband_strobe_first && !sb_d)
         begin
            sb_word <= link.sideband_addr;
            sb_tgl <= ~sb_tgl;
         end
      end
   end
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         sb_s1 <= 1'b0;
         sb_s2 <= 1'b0;
         sb_s3 <= 1'b0;
         o_sb_valid <= 1'b0;
         o_sb_addr <= 8'h0;
      end
      else
      begin
         sb_s1 <= sb_tgl;
         sb_s2 <= sb_s1;
         sb_s3 <= sb_s2;
         o_sb_valid <= sb_s2 ^ sb_s3;
         if (sb_s2 ^ sb_s3)
            o_sb_addr <= sb_word;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/gport_if.sv */
// Link between arbiter/target end and graphics master end.
// Assumes the bench drives link_clk; two-way strobes use enables.
`timescale 1ns/100ps
`default_nettype none
interface gport_if;
   logic link_clk;
   logic [2:0] grant_status;
   logic bus_grant;
   logic read_buffer_full;
   logic pipelined_request;
   logic transaction_frame;
   logic new_mode;
   // Data lanes driven by one agent at a time
   logic [31:0] dev_ad;
   logic [31:0] mst_ad;
   logic [3:0] dev_cbe;
   logic [3:0] mst_cbe;
   logic dev_inv_hi;
   logic dev_inv_lo;
   logic mst_inv_hi;
   logic mst_inv_lo;
   logic dev_oe;
   logic mst_oe;
   // Strobes: index 0 lower lane, 1 upper lane; first and second per lane
   logic [1:0] dev_stb_first;
   logic [1:0] dev_stb_second;
   logic [1:0] mst_stb_first;
   logic [1:0] mst_stb_second;
   // Sideband address with its strobes
   logic [7:0] sideband_addr;
   logic sideband_strobe_first;
   logic sideband_strobe_second;
   logic sideband_4x_enable;
   // Resolved wires
   wire [31:0] addr_data_bus = dev_oe ? dev_ad : (mst_oe ? mst_ad : 32'h0);
   wire [3:0] cmd_byte_enable = dev_oe ? dev_cbe : (mst_oe ? mst_cbe : 4'h0);
   wire bus_invert_hi = dev_oe ? dev_inv_hi : (mst_oe ? mst_inv_hi : 1'b0);
   wire bus_invert_lo = dev_oe ? dev_inv_lo : (mst_oe ? mst_inv_lo : 1'b0);
   wire [1:0] strobe_first = dev_oe ? dev_stb_first : mst_stb_first;
   wire [1:0] strobe_second = dev_oe ? dev_stb_second : mst_stb_second;
   modport device (input link_clk, output grant_status, output bus_grant,
      input read_buffer_full, input pipelined_request, input transaction_frame,
      input new_mode, output dev_ad, output dev_cbe, output dev_inv_hi,
      output dev_inv_lo, output dev_oe, output dev_stb_first, output dev_stb_second,
      input addr_data_bus, input cmd_byte_enable, input bus_invert_hi,
      input bus_invert_lo, input strobe_first, input strobe_second, input mst_oe,
      input sideband_addr, input sideband_strobe_first, input sideband_strobe_second,
      input sideband_4x_enable);
   modport master (input link_clk, input grant_status, input bus_grant,
      output read_buffer_full, output pipelined_request, output transaction_frame,
      input new_mode, output mst_ad, output mst_cbe, output mst_inv_hi,
      output mst_inv_lo, output mst_oe, output mst_stb_first, output mst_stb_second,
      input addr_data_bus, input cmd_byte_enable, input bus_invert_hi,
      input bus_invert_lo, input dev_oe, output sideband_addr,
      output sideband_strobe_first, output sideband_strobe_second,
      input sideband_4x_enable);
endinterface
`default_nettype wire

/* File: rtl/gport_master.sv */
// Graphics master end: obeys grants, supplies write data, receives reads.
// Assumes link_clk from the bench; user side runs on i_mclk.
`timescale 1ns/100ps
`default_nettype none
module gport_master
   import gport_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_wr_valid,
   input wire logic [31:0] i_wr_data,
   output logic o_wr_ready,
   input wire logic i_rbuf_full,
   output logic o_rd_valid,
   output logic [31:0] o_rd_data,
   output logic o_start_seen,
   gport_if.master link
);
   // ==========================================
   // Write word crossing by toggle handshake
   logic [31:0] wr_hold;
   logic wr_tgl;
   logic ack_s1;
   logic ack_s2;
   logic ack_tgl;
   logic busy;
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         wr_tgl <= 1'b0;
         wr_hold <= 32'h0;
         busy <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         o_wr_ready <= 1'b0;
      end
      else
      begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
         o_wr_ready <= !busy && !(i_wr_valid && o_wr_ready);
         if (i_wr_valid && o_wr_ready)
         begin
            wr_hold <= i_wr_data;
            wr_tgl <= ~wr_tgl;
            busy <= 1'b1;
         end
         else if (busy && (ack_s2 == wr_tgl))
            busy <= 1'b0;
      end
   end
   // ==========================================
   // Link side: decode grant status only while granted
   logic wr_s1;
   logic wr_s2;
   logic rbf_s1;
   logic rbf_s2;
   logic drive;
   logic [1:0] beat;
   logic start_tgl;
   logic gnt_d;
   wire logic is_write = link.bus_grant &&
      (link.grant_status == ST_WRITE_LO || link.grant_status == ST_WRITE_HI);
   wire logic is_start = link.bus_grant && link.grant_status == ST_START;
   always_ff @(posedge link.link_clk)
   begin
      if (i_rst)
      begin
         wr_s1 <= 1'b0;
         wr_s2 <= 1'b0;
         rbf_s1 <= 1'b0;
         rbf_s2 <= 1'b0;
         ack_tgl <= 1'b0;
         drive <= 1'b0;
         beat <= 2'h0;
         start_tgl <= 1'b0;
         gnt_d <= 1'b0;
         link.mst_oe <= 1'b0;
         link.mst_stb_first <= 2'h0;
         link.mst_stb_second <= 2'h0;
      end
      else
      begin
         wr_s1 <= wr_tgl;
         wr_s2 <= wr_s1;
         rbf_s1 <= i_rbuf_full;
         rbf_s2 <= rbf_s1;
         gnt_d <= link.bus_grant;
         if (is_start && !gnt_d)
            start_tgl <= ~start_tgl;
         if (is_write && !gnt_d)
         begin
            drive <= 1'b1;
            beat <= 2'h0;
            link.mst_oe <= 1'b1;
         end
         else if (drive)
         begin
            beat <= beat + 2'h1;
            link.mst_stb_first <= {2{~beat[0]}};
            link.mst_stb_second <= {2{beat[0]}};
            if (beat == 2'h3)
            begin
               drive <= 1'b0;
               link.mst_oe <= 1'b0;
               link.mst_stb_first <= 2'h0;
               link.mst_stb_second <= 2'h0;
               ack_tgl <= wr_s2;
            end
         end
      end
   end
   // Write data with upper half inverted in new mode when bits 31:24 are all ones
   wire logic inv_hi = link.new_mode && (wr_hold[31:24] == 8'hFF);
   assign link.mst_ad = {inv_hi ? ~wr_hold[31:16] : wr_hold[31:16], wr_hold[15:0]};
   assign link.mst_cbe = 4'hF;
   assign link.mst_inv_hi = inv_hi;
   assign link.mst_inv_lo = 1'b0;
   assign link.read_buffer_full = rbf_s2;
   assign link.pipelined_request = 1'b0;
   assign link.transaction_frame = 1'b0;
   assign link.sideband_addr = 8'h0;
   assign link.sideband_strobe_first = 1'b0;
   assign link.sideband_strobe_second = 1'b0;
   // ==========================================
   // Read capture on rise of device output enable dev_oe, crossed by toggle
   logic stb_d;
   logic [31:0] rd_word;
   logic rd_tgl;
   always_ff @(posedge link.link_clk)
   begin
      if (i_rst)
      begin
         stb_d <= 1'b0;
         rd_word <= 32'h0;
         rd_tgl <= 1'b0;
      end
      else
      begin
         stb_d <= link.mst_stb_first[1] | link.dev_oe;
         if (link.dev_oe && !stb_d)
         begin
            rd_word <= link.addr_data_bus;
            rd_tgl <= ~rd_tgl;
         end
      end
   end
   logic r1;
   logic r2;
   logic r3;
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         r1 <= 1'b0;
         r2 <= 1'b0;
         r3 <= 1'b0;
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         o_rd_valid <= 1'b0;
         o_rd_data <= 32'h0;
         o_start_seen <= 1'b0;
      end
      else
      begin
         r1 <= rd_tgl;
         r2 <= r1;
         r3 <= r2;
         s1 <= start_tgl;
         s2 <= s1;
         s3 <= s2;
         o_rd_valid <= r2 ^ r3;
         if (r2 ^ r3)
            o_rd_data <= rd_word;
         o_start_seen <= s2 ^ s3;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/gport_pkg.sv */
// Shared constants for the graphics port grant status and strobe ends.
// Assumes both ends import this package; no tool settings needed.
package gport_pkg;
   // ==========================================
   // Grant status codes
   localparam logic [2:0] ST_READ_LO = 3'h0;
   localparam logic [2:0] ST_READ_HI = 3'h1;
   localparam logic [2:0] ST_WRITE_LO = 3'h2;
   localparam logic [2:0] ST_WRITE_HI = 3'h3;
   localparam logic [2:0] ST_START = 3'h7;
   // ==========================================
   // Bus geometry
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int HALF_W = 16;
   localparam int SB_W = 8;
   localparam int BUF_DEPTH = 2;
   // ==========================================
   // Request kinds from user side of the device
   typedef enum logic [1:0] {REQ_READ_LO, REQ_READ_HI, REQ_WRITE_LO, REQ_WRITE_HI} req_kind_t;
endpackage

/* File: verification/gport_link_assertions.sv */
// Checker for the grant status and data strobe link between both ends.
// Assumes the bench feeds it the interface signals and the shared reset.
`timescale 1ns/100ps
`default_nettype none
module gport_link_checker
(
   input wire logic link_clk,
   input wire logic i_rst,
   input wire logic [2:0] grant_status,
   input wire logic bus_grant,
   input wire logic read_buffer_full,
   input wire logic new_mode,
   input wire logic dev_oe,
   input wire logic mst_oe,
   input wire logic [1:0] dev_stb_first,
   input wire logic [1:0] dev_stb_second,
   input wire logic dev_inv_hi,
   input wire logic dev_inv_lo
);
   default clocking link_cb @(posedge link_clk);
   endclocking
   default disable iff (i_rst);
   // ==========================================
   // Grant status codes
   AST_NO_RESERVED: assert property (bus_grant |-> !(grant_status inside {3'h4, 3'h5, 3'h6}))
      else $error("reserved grant status driven");
   AST_NEW_NO_HIGH: assert property (bus_grant && new_mode |-> !grant_status[0] || grant_status[2])
      else $error("high priority status in new mode");
   AST_GRANT_PULSE: assert property (bus_grant |=> !bus_grant)
      else $error("grant longer than one cycle");
   AST_READ_FULL: assert property (bus_grant && grant_status == 3'h0 |-> !$past(read_buffer_full))
      else $error("low read returned while buffer full");
   AST_START_IDLE: assert property (bus_grant && grant_status == 3'h7 |=> !dev_oe)
      else $error("device drives data after start grant");
   // ==========================================
   // Data phases and strobes
   AST_READ_DRIVE: assert property (bus_grant && grant_status[2:1] == 2'h0 |-> ##[1:2] dev_oe)
      else $error("read grant without device data");
   AST_WRITE_DRIVE: assert property (bus_grant && grant_status[2:1] == 2'h1 |-> ##[1:3] mst_oe)
      else $error("write grant without master data");
   AST_ONE_AGENT: assert property (!(dev_oe && mst_oe))
      else $error("both agents drive the data lanes");
   AST_PHASE_LEN: assert property ($rose(dev_oe) |-> dev_oe[*4] ##1 !dev_oe)
      else $error("device data phase not four items");
   AST_STB_SPLIT: assert property (dev_oe |-> !(dev_stb_first[0] && dev_stb_second[0]))
      else $error("first and second strobe high together");
   AST_NO_INVERT: assert property (dev_oe |-> !dev_inv_hi && !dev_inv_lo)
      else $error("device read data sent inverted");
   // ==========================================
   // Main scenarios
   COV_READ: cover property (bus_grant && grant_status == 3'h0);
   COV_WRITE: cover property (bus_grant && grant_status == 3'h2);
   COV_START: cover property (bus_grant && grant_status == 3'h7);
   COV_MASTER_DATA: cover property ($rose(mst_oe));
endmodule
`default_nettype wire

/* File: verification/tb_graphics_port_grant_status_strobes.sv */
// Testbench joining the device and master ends across the link interface.
// Assumes the rtl package, interface and both ends are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_graphics_port_grant_status_strobes
   import gport_pkg::*;
;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic req_valid = 1'b0, start_grant = 1'b0, rx_ready = 1'b1;
   logic wr_valid = 1'b0, rbuf_full = 1'b0;
   req_kind_t req_kind = REQ_READ_LO;
   logic [31:0] req_data = 32'h0, wr_data = 32'h0;
   logic [3:0] req_be = 4'hF;
   logic req_ready, rx_valid, sb_valid, wr_ready, rd_valid, start_seen;
   logic [31:0] rx_data, rd_data;
   int n_mismatch = 0;
   int checks_done = 0;
   gport_if gport_if_i();
   // ==========================================
   // Clocks and link levels
   always #25 i_mclk = ~i_mclk;
   initial
   begin
      gport_if_i.link_clk = 1'b0;
      gport_if_i.new_mode = 1'b0;
      gport_if_i.sideband_4x_enable = 1'b1;
      #13;
      forever #80 gport_if_i.link_clk = ~gport_if_i.link_clk;
   end
   gport_device gport_device_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_valid(req_valid),
      .i_req_kind(req_kind), .i_req_data(req_data), .i_req_be(req_be), .o_req_ready(req_ready),
      .i_start_grant(start_grant), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_be(),
      .i_rx_ready(rx_ready), .o_sb_addr(), .o_sb_valid(sb_valid), .link(gport_if_i.device));
   gport_master gport_master_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr_valid(wr_valid),
      .i_wr_data(wr_data), .o_wr_ready(wr_ready), .i_rbuf_full(rbuf_full), .o_rd_valid(rd_valid),
      .o_rd_data(rd_data), .o_start_seen(start_seen), .link(gport_if_i.master));
   gport_link_checker gport_link_checker_i (.link_clk(gport_if_i.link_clk), .i_rst(i_rst),
      .grant_status(gport_if_i.grant_status), .bus_grant(gport_if_i.bus_grant),
      .read_buffer_full(gport_if_i.read_buffer_full), .new_mode(gport_if_i.new_mode),
      .dev_oe(gport_if_i.dev_oe), .mst_oe(gport_if_i.mst_oe),
      .dev_stb_first(gport_if_i.dev_stb_first), .dev_stb_second(gport_if_i.dev_stb_second),
      .dev_inv_hi(gport_if_i.dev_inv_hi), .dev_inv_lo(gport_if_i.dev_inv_lo));
   // ==========================================
   // Compare, report and closing tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ==========================================
   // Access tasks on both user sides
   task automatic dev_req(input req_kind_t kind, input logic [31:0] data);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_kind <= kind;
      req_data <= data;
      @(posedge i_mclk);
      while (req_ready !== 1'b1 && n < 400)
      begin
         @(posedge i_mclk);
         n++;
      end
      req_valid <= 1'b0;
      check("request taken", {31'h0, req_ready}, 32'h1);
   endtask
   task automatic mst_word(input logic [31:0] data);
      int n;
      n = 0;
      wr_valid <= 1'b1;
      wr_data <= data;
      @(posedge i_mclk);
      while (wr_ready !== 1'b1 && n < 400)
      begin
         @(posedge i_mclk);
         n++;
      end
      wr_valid <= 1'b0;
      check("write word taken", {31'h0, wr_ready}, 32'h1);
   endtask
   // Waits for a flag at a clock edge, up to the given count
   task automatic wait_flag(ref logic flag, input int limit);
      int n;
      n = 0;
      @(posedge i_mclk);
      while (flag !== 1'b1 && n < limit)
      begin
         @(posedge i_mclk);
         n++;
      end
   endtask
   task automatic get_rd(input string what, input logic [31:0] exp);
      wait_flag(rd_valid, 400);
      check(what, rd_data, exp);
      $display("test %s done", what);
   endtask
   task automatic get_rx(input string what, input logic [31:0] exp);
      wait_flag(rx_valid, 400);
      check(what, rx_data, exp);
      $display("test %s done", what);
   endtask
   // ==========================================
   // Test sequence
   initial
   begin
      repeat (13) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      dev_req(REQ_READ_LO, 32'hA5C3_0F1E);
      get_rd("old low read", 32'hA5C3_0F1E);
      dev_req(REQ_READ_HI, 32'h1234_8765);
      get_rd("old high read", 32'h1234_8765);
      rx_ready <= 1'b0;
      mst_word(32'hDEAD_0001);
      dev_req(REQ_WRITE_LO, 32'h0);
      mst_word(32'h7E57_0002);
      dev_req(REQ_WRITE_HI, 32'h0);
      repeat (300) @(posedge i_mclk);
      check("stalled write", rx_data, 32'hDEAD_0001);
      rx_ready <= 1'b1;
      get_rx("old low write", 32'hDEAD_0001);
      get_rx("old high write", 32'h7E57_0002);
      start_grant <= 1'b1;
      @(posedge i_mclk);
      start_grant <= 1'b0;
      wait_flag(start_seen, 400);
      check("start grant", {31'h0, start_seen}, 32'h1);
      rbuf_full <= 1'b1;
      repeat (20) @(posedge i_mclk);
      dev_req(REQ_READ_LO, 32'h0BAD_F00D);
      wait_flag(rd_valid, 300);
      check("read while full", {31'h0, rd_valid}, 32'h0);
      rbuf_full <= 1'b0;
      get_rd("read after full", 32'h0BAD_F00D);
      gport_if_i.new_mode <= 1'b1;
      repeat (10) @(posedge i_mclk);
      dev_req(REQ_READ_HI, 32'h5555_AAAA);
      wait_flag(rd_valid, 300);
      check("new high read", {31'h0, rd_valid}, 32'h0);
      dev_req(REQ_READ_LO, 32'hFFEE_0102);
      get_rd("new low read", 32'hFFEE_0102);
      mst_word(32'hFF34_5678);
      dev_req(REQ_WRITE_LO, 32'h0);
      get_rx("new inverted write", 32'hFF34_5678);
      check("sideband idle", {31'h0, sb_valid}, 32'h0);
      wrap_up;
   end
   // Watchdog against a hung handshake
   initial
   begin
      #2000000;
      n_mismatch++;
      wrap_up;
   end
endmodule
`default_nettype wire
